// ---- verilog/itm_map.svh ----
/*
  register offsets, field positions, reset values and timing counts of the
  16-bit interval timer. assumes nothing; definitions only.
*/
`ifndef ITM_MAP_SVH
`define ITM_MAP_SVH
`define ITM_OFS_CTRL      12'h000
`define ITM_OFS_CMP       12'h004
`define ITM_OFS_STATUS    12'h008
`define ITM_OFS_MASK      12'h00C
`define ITM_CTRL_RUN_BIT  7
`define ITM_CTRL_SEL_LSB  0
`define ITM_CTRL_RESET    8'h00
`define ITM_CMP_RESET     16'h0000
`define ITM_CTRL_WMASK    8'h87
`define ITM_CNT_IDLE      16'hFFFF
`define ITM_DIV_64        9'h03F
`define ITM_DIV_512       9'h1FF
`define ITM_OSC_DIV       3'h7
`define ITM_SYNC_STAGES   3
`endif

// ---- verilog/itm_pkg.sv ----
/*
  types shared by the interval timer files.
  assumes itm_map.svh is reachable by the include path.
*/
package itm_pkg;
  typedef enum logic [2:0] {
    ITM_SEL_MAIN  = 3'h0,
    ITM_SEL_DIV2  = 3'h1,
    ITM_SEL_DIV4  = 3'h2,
    ITM_SEL_DIV64 = 3'h3,
    ITM_SEL_DIV512= 3'h4,
    ITM_SEL_WATCH = 3'h5,
    ITM_SEL_OSC8  = 3'h6,
    ITM_SEL_SUB   = 3'h7
  } itm_sel_t;
  typedef enum logic [2:0] {
    ITM_ST_IDLE  = 3'b001,
    ITM_ST_ARMED = 3'b010,
    ITM_ST_RUN   = 3'b100
  } itm_state_t;
endpackage

// ---- verilog/itm_pin_sync.sv ----
/*
  three-flop synchroniser for asynchronous pins with rising-edge pulse.
  assumes clk_sys domain; a rise counts when stage two is high and stage three still low.
*/
`timescale 1ns/1ps
`default_nettype none
module itm_pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] rise
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
  } itm_sync_state_t;
  itm_sync_state_t q;
  itm_sync_state_t next_q;
  // shift chain; first stage read by the second only
  always_comb begin
    next_q    = q;
    next_q.s1 = pin_in;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
  // edge seen when stage two is new high and stage three still low
  assign rise = q.s2 & ~q.s3;
endmodule
`default_nettype wire

// ---- verilog/itm_prescaler.sv ----
/*
  prescaler that makes one-cycle count enables for each clock choice.
  assumes synchronised source pulses on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
`include "itm_map.svh"
module itm_prescaler
  import itm_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic [2:0] sel,
  input  wire logic watch_rise,
  input  wire logic osc_rise,
  input  wire logic sub_rise,
  output logic      tick
);
  typedef struct packed {
    logic [8:0] div;
    logic [2:0] osc_div;
  } itm_pre_state_t;
  itm_pre_state_t q;
  itm_pre_state_t next_q;
  // dividers free while running, cleared while stopped
  always_comb begin
    next_q = q;
    if (!run) begin
      next_q = '0;
    end else begin
      next_q.div = q.div + 9'h001;
      if (osc_rise) begin
        next_q.osc_div = q.osc_div + 3'h1;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
  // count clock choice
  always_comb begin
    case (itm_sel_t'(sel))
      ITM_SEL_MAIN:   tick = run;
      ITM_SEL_DIV2:   tick = run & q.div[0];
      ITM_SEL_DIV4:   tick = run & (q.div[1:0] == 2'h3);
      ITM_SEL_DIV64:  tick = run & ({3'h0, q.div[5:0]} == `ITM_DIV_64);
      ITM_SEL_DIV512: tick = run & (q.div == `ITM_DIV_512);
      ITM_SEL_WATCH:  tick = run & watch_rise;
      ITM_SEL_OSC8:   tick = run & osc_rise & (q.osc_div == `ITM_OSC_DIV);
      ITM_SEL_SUB:    tick = run & sub_rise;
      default:        tick = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ---- verilog/itm_timer.sv ----
/*
  16-bit interval timer with axi4-lite register slave, compare match,
  sticky status and mask. assumes one clock clk_sys at 100 MHz; watch,
  oscillator and subclock arrive as asynchronous pins.
*/
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "itm_map.svh"
// Functional notes
// - eight-bit control register, byte or bit writable, resets to zero
// - rewriting the current control value never disturbs counting
// - run enable low stops the timer and holds counter at reset value
// - on enable, counter leaves all-ones for zero at a count clock
// - counter equal to compare clears to zero and raises match interrupt
// - match period is compare plus one count clock periods
// - compare zero gives a match every count clock, counter stays zero
// - counter reaches N, then clears with interrupt on next count
// - counting starts within bounded delay for each clock choice
// - sixteen-bit compare register, word access, resets to zero
module itm_timer
  import itm_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        watch_timer_irq,
  input  wire logic        internal_osc_clk,
  input  wire logic        subclock,
  output logic             compare_match_irq,
  output logic             irq
);
  typedef struct packed {
    logic [1:0]  rst_sync;
    logic [7:0]  ctrl;
    logic [15:0] cmp;
    logic [15:0] count;
    itm_state_t  state;
    logic        match;
    logic        status;
    logic        mask;
    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } itm_state_all_t;

  // reset release through two flops
  logic [1:0] rst_pipe;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  logic rst_n;
  assign rst_n = rst_pipe[1];

  itm_state_all_t q;
  itm_state_all_t next_q;
  logic [2:0]     pin_rise;
  logic           tick;
  logic           run;

  // asynchronous source pins pass three flops
  itm_pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_in  ({subclock, internal_osc_clk, watch_timer_irq}),
    .rise    (pin_rise)
  );

  assign run = q.ctrl[`ITM_CTRL_RUN_BIT];

  // count clock enables from the selected source
  itm_prescaler u_pre (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .run        (run),
    .sel        (q.ctrl[2:0]),
    .watch_rise (pin_rise[0]),
    .osc_rise   (pin_rise[1]),
    .sub_rise   (pin_rise[2]),
    .tick       (tick)
  );

  // byte-lane merge of a write into a register word
  function automatic logic [31:0] itm_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // decode of a register offset
  function automatic logic itm_hit(input logic [11:0] addr,
                                   input logic [11:0] ofs);
    return (addr[11:2] == ofs[11:2]);
  endfunction

  logic [31:0] wr_ctrl;
  logic [31:0] wr_cmp;
  logic        do_write;
  logic        do_read;

  // register file, counter and bus slave next state
  always_comb begin
    next_q   = q;
    wr_ctrl  = itm_merge({24'h0, q.ctrl}, q.w_data, q.w_strb);
    wr_cmp   = itm_merge({16'h0, q.cmp}, q.w_data, q.w_strb);
    do_write = q.aw_held && q.w_held && !q.bvalid;
    do_read  = s_axi_arvalid && !q.rvalid;
    next_q.match = 1'b0;

    // write channels taken independently
    if (s_axi_awvalid && !q.aw_held) begin
      next_q.aw_held = 1'b1;
      next_q.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_held) begin
      next_q.w_held = 1'b1;
      next_q.w_data = s_axi_wdata;
      next_q.w_strb = s_axi_wstrb;
    end

    // counter: idle value while stopped, sync start, compare clear
    case (q.state)
      ITM_ST_IDLE: begin
        next_q.count = `ITM_CNT_IDLE;
        if (run) begin
          next_q.state = ITM_ST_ARMED;
        end
      end
      ITM_ST_ARMED: begin
        if (tick) begin
          next_q.count = 16'h0000;
          next_q.state = ITM_ST_RUN;
        end
      end
      ITM_ST_RUN: begin
        if (tick) begin
          if (q.count == q.cmp) begin
            next_q.count = 16'h0000;
            next_q.match = 1'b1;
          end else begin
            next_q.count = q.count + 16'h0001;
          end
        end
      end
      default: begin
        next_q.state = ITM_ST_IDLE;
      end
    endcase
    if (!run) begin
      next_q.state = ITM_ST_IDLE;
      next_q.count = `ITM_CNT_IDLE;
    end

    // register write; same value leaves the counter untouched
    if (do_write) begin
      next_q.aw_held = 1'b0;
      next_q.w_held  = 1'b0;
      next_q.bvalid  = 1'b1;
      next_q.bresp   = 2'b00;
      if (itm_hit(q.aw_addr, `ITM_OFS_CTRL)) begin
        next_q.ctrl = wr_ctrl[7:0] & `ITM_CTRL_WMASK;
        if (!wr_ctrl[`ITM_CTRL_RUN_BIT]) begin
          next_q.state = ITM_ST_IDLE;
          next_q.count = `ITM_CNT_IDLE;
        end
      end else if (itm_hit(q.aw_addr, `ITM_OFS_CMP)) begin
        next_q.cmp = wr_cmp[15:0];
      end else if (itm_hit(q.aw_addr, `ITM_OFS_STATUS)) begin
        if (q.w_strb[0] && q.w_data[0]) begin
          next_q.status = 1'b0;
        end
      end else if (itm_hit(q.aw_addr, `ITM_OFS_MASK)) begin
        if (q.w_strb[0]) begin
          next_q.mask = q.w_data[0];
        end
      end else begin
        next_q.bresp = 2'b10;
      end
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end

    // sticky status; a match wins over a clear in the same cycle
    if (next_q.match) begin
      next_q.status = 1'b1;
    end

    // read answer
    if (do_read) begin
      next_q.rvalid = 1'b1;
      next_q.rresp  = 2'b00;
      if (itm_hit(s_axi_araddr, `ITM_OFS_CTRL)) begin
        next_q.rdata = {24'h0, q.ctrl};
      end else if (itm_hit(s_axi_araddr, `ITM_OFS_CMP)) begin
        next_q.rdata = {16'h0, q.cmp};
      end else if (itm_hit(s_axi_araddr, `ITM_OFS_STATUS)) begin
        next_q.rdata = {29'h0, q.state == ITM_ST_RUN, run, q.status};
      end else if (itm_hit(s_axi_araddr, `ITM_OFS_MASK)) begin
        next_q.rdata = {31'h0, q.mask};
      end else begin
        next_q.rdata = 32'h0000_0000;
        next_q.rresp = 2'b10;
      end
    end else if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q       <= '0;
      q.ctrl  <= `ITM_CTRL_RESET;
      q.cmp   <= `ITM_CMP_RESET;
      q.count <= `ITM_CNT_IDLE;
      q.state <= ITM_ST_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // bus handshakes and outputs
  assign s_axi_awready     = !q.aw_held;
  assign s_axi_wready      = !q.w_held;
  assign s_axi_bvalid      = q.bvalid;
  assign s_axi_bresp       = q.bresp;
  assign s_axi_arready     = !q.rvalid;
  assign s_axi_rvalid      = q.rvalid;
  assign s_axi_rdata       = q.rdata;
  assign s_axi_rresp       = q.rresp;
  assign compare_match_irq = q.match;
  assign irq               = q.status & q.mask;
endmodule
`default_nettype wire

// ---- bench/itm_timer_asserts.sv ----
/*
  port checker for the interval timer.
  assumes write address and write data are offered together.
*/
`timescale 1ns/1ps
`default_nettype none
`include "itm_map.svh"
module itm_timer_asserts (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        compare_match_irq,
  input wire logic        irq
);
  logic [11:0] rd_ofs;
  logic        run_sh;
  logic        mask_sh;
  logic        wr_go;
  logic [2:0]  idle_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  sequence wr_taken;
    wr_go;
  endsequence
  // shadows of run bit, mask bit and last read offset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_ofs   <= 12'h000;
      run_sh   <= 1'b0;
      mask_sh  <= 1'b0;
      idle_cnt <= 3'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) rd_ofs <= s_axi_araddr;
      if (wr_go && s_axi_awaddr == `ITM_OFS_CTRL) run_sh <= s_axi_wdata[7];
      if (wr_go && s_axi_awaddr == `ITM_OFS_MASK) mask_sh <= s_axi_wdata[0];
      idle_cnt <= run_sh ? 3'h0 : (idle_cnt == 3'h4 ? idle_cnt : idle_cnt + 3'h1);
    end
  end
  a_wr_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_ctrl_rsvd: assert property (s_axi_rvalid && rd_ofs == `ITM_OFS_CTRL |->
    s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[6:3] == 4'h0) else $error("ctrl spare bits");
  a_cmp_width: assert property (s_axi_rvalid && rd_ofs == `ITM_OFS_CMP |->
    s_axi_rdata[31:16] == 16'h0) else $error("compare too wide");
  a_bad_ofs: assert property (s_axi_rvalid && rd_ofs > `ITM_OFS_MASK |->
    s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read");
  a_stop_quiet: assert property (idle_cnt == 3'h4 |-> !compare_match_irq)
    else $error("match while stopped");
  a_irq_masked: assert property (irq |-> mask_sh || $past(mask_sh, 2))
    else $error("irq while masked");
endmodule
bind itm_timer itm_timer_asserts chk_u (
  .clk_sys, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .compare_match_irq, .irq
);
`default_nettype wire

// ---- bench/interval_timer_16bit_bench.sv ----
/*
  bench for the interval timer: registers, interval for every clock
  choice, stop, match status and interrupt. assumes the timer sources.
*/
`timescale 1ns/1ps
`default_nettype none
`include "itm_map.svh"
module interval_timer_16bit_bench;
  logic        clk_sys, arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, cmi, irq, wt, osc, sub;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  pc;
  int          fail_count, n_tests;
  int          cm[9] = '{3, 5, 2, 1, 0, 0, 0, 1, 0};
  int          ex[9] = '{4, 12, 12, 128, 512, 64, 32, 32, 1};
  itm_timer dut_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .watch_timer_irq(wt), .internal_osc_clk(osc),
    .subclock(sub), .compare_match_irq(cmi), .irq(irq)
  );
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // slow sources: watch 64, osc 4, sub 16 cycles
  always @(posedge clk_sys) begin
    pc  <= pc + 8'h01;
    wt  <= pc[5];
    osc <= pc[1];
    sub <= pc[3];
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic tmo();
    fail_count++;
    finish_test();
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // one write, each channel released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    repeat (40) begin
      @(negedge clk_sys);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      @(posedge clk_sys);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    repeat (40) begin
      @(negedge clk_sys);
      ta = arvalid && arready;
      tr = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge clk_sys);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask
  // cycles until the next match pulse
  task automatic gap(output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (cmi !== 1'b1 && n < 4000);
    if (n >= 4000) tmo();
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rd(`ITM_OFS_CTRL, d, r);
    chk(d, 32'h0);
    rd(`ITM_OFS_CMP, d, r);
    chk(d, 32'h0);
    rd(12'h010, d, r);
    chk(r, 2'b10);
    wr(12'h010, 32'h0);
    chk(bresp, 2'b10);
    wr(`ITM_OFS_CTRL, 32'h78);
    chk(bresp, 2'b00);
    rd(`ITM_OFS_CTRL, d, r);
    chk(d, 32'h0);
  endtask
  task automatic t_interval();
    logic [31:0] d;
    logic [1:0]  r;
    int          i, n, k;
    for (i = 0; i < 9; i++) begin
      wr(`ITM_OFS_CTRL, 32'h0);
      repeat (4) @(negedge clk_sys);
      k = 0;
      repeat (16) begin
        @(negedge clk_sys);
        k += (cmi !== 1'b0);
      end
      chk(k, 0);
      wr(`ITM_OFS_CMP, cm[i]);
      rd(`ITM_OFS_CMP, d, r);
      chk(d, cm[i]);
      wr(`ITM_OFS_CTRL, 32'h80 | (i % 8));
      gap(n);
      chk(n <= 3 * ex[i] + 8, 1'b1);
      gap(n);
      chk(n, ex[i]);
      rd(`ITM_OFS_CTRL, d, r);
      chk(d, 32'h80 | (i % 8));
      wr(`ITM_OFS_CTRL, d);
      gap(n);
      gap(n);
      chk(n, ex[i]);
    end
  endtask
  task automatic t_irq();
    logic [31:0] d;
    logic [1:0]  r;
    rd(`ITM_OFS_STATUS, d, r);
    chk(d[0], 1'b1);
    chk(irq, 1'b0);
    wr(`ITM_OFS_MASK, 32'h1);
    @(negedge clk_sys);
    chk(irq, 1'b1);
    wr(`ITM_OFS_CTRL, 32'h0);
    wr(`ITM_OFS_STATUS, 32'h1);
    @(negedge clk_sys);
    chk(irq, 1'b0);
    rd(`ITM_OFS_STATUS, d, r);
    chk(d[0], 1'b0);
    wr(`ITM_OFS_MASK, 32'h0);
  endtask
  initial begin
    arst_n     = 1'b0;
    awvalid    = 1'b0;
    wvalid     = 1'b0;
    bready     = 1'b0;
    arvalid    = 1'b0;
    rready     = 1'b0;
    awaddr     = 12'h000;
    araddr     = 12'h000;
    wdata      = 32'h0;
    wstrb      = 4'hF;
    pc         = 8'h00;
    wt         = 1'b0;
    osc        = 1'b0;
    sub        = 1'b0;
    fail_count = 0;
    n_tests    = 0;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs();
    t_interval();
    t_irq();
    finish_test();
  end
endmodule
`default_nettype wire
